// [common/viru_defs.svh]
// Constants of the vectored interrupt request unit: offsets, fields, vectors.
// Assumes byte addressing on a 32-bit bus with word-aligned registers.
`ifndef VIRU_DEFS_SVH
`define VIRU_DEFS_SVH

// Register byte offsets within the decoded 4 KB window.
`define VIRU_ADDR_W 12
`define VIRU_OFF_REQ 12'hFC0
`define VIRU_OFF_ENA 12'hFC4
`define VIRU_OFF_PFLG 12'hFC8
`define VIRU_OFF_PENA 12'hFCC
`define VIRU_OFF_EDGE 12'hFD0
`define VIRU_OFF_CTRL 12'hFD4
`define VIRU_OFF_RCAUSE 12'hFD8
`define VIRU_OFF_STAT 12'hFDC
`define VIRU_OFF_MASK 12'hFE0
`define VIRU_OFF_VEC 12'hFE4

// Reset values.
`define VIRU_RST_REQ 8'h00
`define VIRU_RST_PORT 10'h000
`define VIRU_RST_STAT 3'h0

// Request flag field positions.
`define VIRU_BIT_T1 6
`define VIRU_BIT_T0 5
`define VIRU_BIT_RX 4
`define VIRU_BIT_TX 3
`define VIRU_BIT_ADC 0

// Port flag field positions: 7..0 port A pins, then port C pins 2 and 3.
`define VIRU_PBIT_PA7 7
`define VIRU_PBIT_PA6 6
`define VIRU_PBIT_PC2 8
`define VIRU_PBIT_PC3 9

// Control, reset cause and status fields.
`define VIRU_CTRL_GIE 0
`define VIRU_RCAUSE_WDT 5
`define VIRU_STAT_VEC 0
`define VIRU_STAT_TRAP 1
`define VIRU_STAT_WDT 2

// Source indices, highest priority first.
`define VIRU_SRC_RESET 0
`define VIRU_SRC_WDT 1
`define VIRU_SRC_POSC 2
`define VIRU_SRC_WOSC 3
`define VIRU_SRC_ILL 4
`define VIRU_SRC_T1 5
`define VIRU_SRC_T0 6
`define VIRU_SRC_RX 7
`define VIRU_SRC_TX 8
`define VIRU_SRC_ADC 9
`define VIRU_SRC_PA7 10
`define VIRU_SRC_PC3 18
`define VIRU_SRC_PC2 19
`define VIRU_SRC_N 20

// Program memory vectors.
`define VIRU_VEC_RESET 16'h0002
`define VIRU_VEC_WDT 16'h0004
`define VIRU_VEC_POSC 16'h003A
`define VIRU_VEC_WOSC 16'h003C
`define VIRU_VEC_ILL 16'h0006
`define VIRU_VEC_T1 16'h000A
`define VIRU_VEC_T0 16'h000C
`define VIRU_VEC_RX 16'h000E
`define VIRU_VEC_TX 16'h0010
`define VIRU_VEC_ADC 16'h0016
`define VIRU_VEC_PA7 16'h0018
`define VIRU_VEC_STEP 16'h0002
`define VIRU_VEC_PC3 16'h0030
`define VIRU_VEC_PC2 16'h0032

`endif

// [common/viru_pkg.sv]
// Types of the vectored interrupt request unit.
// Assumes viru_defs.svh supplies the numeric constants.
package viru_pkg;

   typedef enum logic [1:0] {
      VIRU_IDLE = 2'b01,
      VIRU_OFFER = 2'b10
   } viru_state_t;

   typedef logic [15:0] viru_vec_t;

endpackage

// [core/viru_edge_detect.sv]
// Edge detector for request pins, rising, falling or both edges per pin.
// Assumes pins are synchronous to hclk; no edge is reported on the first sample.
`timescale 1ns/1ps
module viru_edge_detect
   import viru_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Pins and selection
   input wire logic [WIDTH-1:0] pins,
   input wire logic [WIDTH-1:0] rise_sel,
   input wire logic [WIDTH-1:0] both_sel,
   // Result
   output logic [WIDTH-1:0] edge_pulse
);

   logic [WIDTH-1:0] prev_q;
   logic armed_q;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;

   // Remembers the previous pin levels.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '0;
         armed_q <= 1'b0;
      end else if (ce) begin
         prev_q <= pins;
         armed_q <= 1'b1;
      end
   end

   assign rise = pins & ~prev_q;
   assign fall = ~pins & prev_q;
   assign edge_pulse = armed_q ? ((rise & (rise_sel | both_sel)) | (fall & (~rise_sel | both_sel)))
                               : '0;

endmodule // viru_edge_detect

// [core/viru_prio_pick.sv]
// Fixed priority picker: the lowest set index wins.
// Assumes index 0 is the highest priority source.
`timescale 1ns/1ps
module viru_prio_pick
   import viru_pkg::*;
#(
   parameter int N = 20
) (
   // Pending sources
   input wire logic [N-1:0] pend,
   // Winner
   output logic found,
   output logic [$clog2(N)-1:0] idx
);

   localparam int IW = $clog2(N);

   always_comb begin
      found = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            found = 1'b1;
            idx = IW'(i);
         end
      end
   end

endmodule // viru_prio_pick

// [core/viru_top.sv]
// Vectored interrupt request unit: request latching, fixed priority, vector offer.
// Assumes an AHB-Lite master with single word transfers and a core that acks vectors.
//
// Operation
// - Fixed ranking, one vector per source.
// - Reset first at 0002H, watchdog 0004H.
// - Oscillator fail traps before illegal instruction.
// - Timer, serial and converter vectors in order.
// - Port A pins, selectable edge, 0018H-0026H.
// - Pin 7 vector shared with voltage detector.
// - Pin 6 vector shared with comparator.
// - Port C pins 3, 2 on both edges.
// - Traps bypass control registers; watchdog needs the global enable.
// - Request sets its request flag bit.
// - Globally enabled: forward pending request to core.
// - Globally disabled: no forwarding, software polls flags.
// - Request flag layout, reset zero, read/write.
// - Zero timer bit means nothing pending.
// - Reading reset cause clears watchdog bit.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "viru_defs.svh"
module viru_top
   import viru_pkg::*;
#(
   parameter int SRC_N = `VIRU_SRC_N
) (
   // Clock, reset and enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Peripheral requests, one-cycle pulses
   input wire logic timer1_request,
   input wire logic timer0_request,
   input wire logic serial_rx_request,
   input wire logic serial_tx_request,
   input wire logic converter_request,
   input wire logic low_voltage_detector,
   input wire logic comparator_request,
   // Request pins, levels
   input wire logic [7:0] port_a_pins,
   input wire logic [1:0] port_c_pins,
   // System monitors, one-cycle pulses
   input wire logic watchdog_request,
   input wire logic primary_osc_fail,
   input wire logic watchdog_osc_fail,
   input wire logic illegal_instruction,
   // Processor core
   input wire logic vec_ack,
   output logic vec_valid,
   output logic [15:0] vec_addr,
   output logic vec_trap,
   // Interrupt line
   output logic irq
);

   localparam int IW = $clog2(SRC_N);

   // Vector of a source index.
   function automatic viru_vec_t vec_of(input logic [IW-1:0] i);
      viru_vec_t v;
      v = `VIRU_VEC_RESET;
      unique case (int'(i))
         `VIRU_SRC_RESET: v = `VIRU_VEC_RESET;
         `VIRU_SRC_WDT: v = `VIRU_VEC_WDT;
         `VIRU_SRC_POSC: v = `VIRU_VEC_POSC;
         `VIRU_SRC_WOSC: v = `VIRU_VEC_WOSC;
         `VIRU_SRC_ILL: v = `VIRU_VEC_ILL;
         `VIRU_SRC_T1: v = `VIRU_VEC_T1;
         `VIRU_SRC_T0: v = `VIRU_VEC_T0;
         `VIRU_SRC_RX: v = `VIRU_VEC_RX;
         `VIRU_SRC_TX: v = `VIRU_VEC_TX;
         `VIRU_SRC_ADC: v = `VIRU_VEC_ADC;
         `VIRU_SRC_PC3: v = `VIRU_VEC_PC3;
         `VIRU_SRC_PC2: v = `VIRU_VEC_PC2;
         default: v = 16'((`VIRU_VEC_PA7) +
                          (`VIRU_VEC_STEP) * 16'(32'(i) - `VIRU_SRC_PA7));
      endcase
      return v;
   endfunction

   // Sources that are traps rather than interrupts.
   function automatic logic is_trap(input logic [IW-1:0] i);
      return (int'(i) == `VIRU_SRC_RESET) || (int'(i) == `VIRU_SRC_POSC) ||
             (int'(i) == `VIRU_SRC_WOSC) || (int'(i) == `VIRU_SRC_ILL);
   endfunction

   // Address decode of a word offset.
   function automatic logic hit(input logic [`VIRU_ADDR_W-1:0] a,
                                input logic [`VIRU_ADDR_W-1:0] off);
      return a[`VIRU_ADDR_W-1:2] == off[`VIRU_ADDR_W-1:2];
   endfunction

   // Bus state.
   logic wr_pend_q;
   logic rd_pend_q;
   logic [`VIRU_ADDR_W-1:0] addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic accept;
   logic wr_now;
   logic rd_now;
   logic [31:0] rd_value;

   // Software-visible registers.
   logic [7:0] req_q;
   logic [7:0] ena_q;
   logic [9:0] pflg_q;
   logic [9:0] pena_q;
   logic [7:0] edge_q;
   logic gie_q;
   logic wdt_cause_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;

   // Internal pending state.
   logic reset_fetch_q;
   logic wdt_pend_q;
   logic posc_q;
   logic wosc_q;
   logic ill_q;

   // Offer state.
   viru_state_t state_q;
   logic [IW-1:0] grant_q;
   logic vec_valid_q;
   viru_vec_t vec_addr_q;
   logic vec_trap_q;
   logic irq_q;

   // Combinational helpers.
   logic [7:0] req_set;
   logic [9:0] pflg_set;
   logic [7:0] pa_edge;
   logic [1:0] pc_edge;
   logic [SRC_N-1:0] pend;
   logic [SRC_N-1:0] take_src;
   logic take;
   logic found;
   logic [IW-1:0] pick;
   logic [2:0] stat_ev;

   assign accept = hsel && hready && htrans[1];
   assign wr_now = wr_pend_q;
   assign rd_now = rd_pend_q;
   assign take = (state_q == VIRU_OFFER) && vec_ack;
   assign take_src = take ? (SRC_N'(1) << grant_q) : '0;

   // Pin edge detectors.
   viru_edge_detect #(.WIDTH(8)) u_pa_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .pins(port_a_pins),
      .rise_sel(edge_q),
      .both_sel(8'h00),
      .edge_pulse(pa_edge)
   );

   viru_edge_detect #(.WIDTH(2)) u_pc_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .pins(port_c_pins),
      .rise_sel(2'h0),
      .both_sel(2'h3),
      .edge_pulse(pc_edge)
   );

   // Hardware set terms of the flag registers.
   always_comb begin
      req_set = 8'h00;
      req_set[`VIRU_BIT_T1] = timer1_request;
      req_set[`VIRU_BIT_T0] = timer0_request;
      req_set[`VIRU_BIT_RX] = serial_rx_request;
      req_set[`VIRU_BIT_TX] = serial_tx_request;
      req_set[`VIRU_BIT_ADC] = converter_request;
      pflg_set = {pc_edge[1], pc_edge[0], pa_edge};
      pflg_set[`VIRU_PBIT_PA7] = pa_edge[7] | low_voltage_detector;
      pflg_set[`VIRU_PBIT_PA6] = pa_edge[6] | comparator_request;
   end

   // Pending sources in priority order; traps ignore the global enable.
   always_comb begin
      pend = '0;
      pend[`VIRU_SRC_RESET] = reset_fetch_q;
      pend[`VIRU_SRC_WDT] = wdt_pend_q & gie_q;
      pend[`VIRU_SRC_POSC] = posc_q;
      pend[`VIRU_SRC_WOSC] = wosc_q;
      pend[`VIRU_SRC_ILL] = ill_q;
      pend[`VIRU_SRC_T1] = req_q[`VIRU_BIT_T1] & ena_q[`VIRU_BIT_T1] & gie_q;
      pend[`VIRU_SRC_T0] = req_q[`VIRU_BIT_T0] & ena_q[`VIRU_BIT_T0] & gie_q;
      pend[`VIRU_SRC_RX] = req_q[`VIRU_BIT_RX] & ena_q[`VIRU_BIT_RX] & gie_q;
      pend[`VIRU_SRC_TX] = req_q[`VIRU_BIT_TX] & ena_q[`VIRU_BIT_TX] & gie_q;
      pend[`VIRU_SRC_ADC] = req_q[`VIRU_BIT_ADC] & ena_q[`VIRU_BIT_ADC] & gie_q;
      for (int i = 0; i < 8; i++) begin
         pend[`VIRU_SRC_PA7 + i] = pflg_q[7 - i] & pena_q[7 - i] & gie_q;
      end
      pend[`VIRU_SRC_PC3] = pflg_q[`VIRU_PBIT_PC3] & pena_q[`VIRU_PBIT_PC3] & gie_q;
      pend[`VIRU_SRC_PC2] = pflg_q[`VIRU_PBIT_PC2] & pena_q[`VIRU_PBIT_PC2] & gie_q;
   end

   viru_prio_pick #(.N(SRC_N)) u_pick (
      .pend(pend),
      .found(found),
      .idx(pick)
   );

   // AHB-Lite slave: zero-wait writes, one wait state on reads.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= '0;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h00000000;
      end else if (ce) begin
         wr_pend_q <= accept && hwrite;
         rd_pend_q <= accept && !hwrite;
         hreadyout_q <= !(accept && !hwrite);
         if (accept) begin
            addr_q <= haddr[`VIRU_ADDR_W-1:0];
         end
         if (rd_now) begin
            hrdata_q <= rd_value;
         end
      end
   end

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      rd_value = 32'h00000000;
      if (hit(addr_q, `VIRU_OFF_REQ)) rd_value = {24'h000000, req_q};
      if (hit(addr_q, `VIRU_OFF_ENA)) rd_value = {24'h000000, ena_q};
      if (hit(addr_q, `VIRU_OFF_PFLG)) rd_value = {22'h000000, pflg_q};
      if (hit(addr_q, `VIRU_OFF_PENA)) rd_value = {22'h000000, pena_q};
      if (hit(addr_q, `VIRU_OFF_EDGE)) rd_value = {24'h000000, edge_q};
      if (hit(addr_q, `VIRU_OFF_CTRL)) rd_value = {31'h00000000, gie_q};
      if (hit(addr_q, `VIRU_OFF_RCAUSE)) begin
         rd_value[`VIRU_RCAUSE_WDT] = wdt_cause_q;
      end
      if (hit(addr_q, `VIRU_OFF_STAT)) rd_value = {29'h00000000, stat_q};
      if (hit(addr_q, `VIRU_OFF_MASK)) rd_value = {29'h00000000, mask_q};
      if (hit(addr_q, `VIRU_OFF_VEC)) rd_value = {15'h0000, vec_valid_q, vec_addr_q};
   end

   // Request flags: software writes, hardware set wins, taken source cleared.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= `VIRU_RST_REQ;
      end else if (ce) begin
         if (wr_now && hit(addr_q, `VIRU_OFF_REQ)) begin
            req_q <= hwdata[7:0] | req_set;
         end else begin
            req_q <= (req_q & ~{1'b0, take_src[`VIRU_SRC_T1], take_src[`VIRU_SRC_T0],
                                take_src[`VIRU_SRC_RX], take_src[`VIRU_SRC_TX], 2'b00,
                                take_src[`VIRU_SRC_ADC]}) | req_set;
         end
      end
   end

   // Port flags behave as the request flags.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pflg_q <= `VIRU_RST_PORT;
      end else if (ce) begin
         if (wr_now && hit(addr_q, `VIRU_OFF_PFLG)) begin
            pflg_q <= hwdata[9:0] | pflg_set;
         end else begin
            pflg_q <= (pflg_q & ~{take_src[`VIRU_SRC_PC3], take_src[`VIRU_SRC_PC2],
                                  take_src[`VIRU_SRC_PA7], take_src[`VIRU_SRC_PA7 + 1],
                                  take_src[`VIRU_SRC_PA7 + 2], take_src[`VIRU_SRC_PA7 + 3],
                                  take_src[`VIRU_SRC_PA7 + 4], take_src[`VIRU_SRC_PA7 + 5],
                                  take_src[`VIRU_SRC_PA7 + 6], take_src[`VIRU_SRC_PA7 + 7]})
                      | pflg_set;
         end
      end
   end

   // Enables, edge select, global enable and status mask.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ena_q <= `VIRU_RST_REQ;
         pena_q <= `VIRU_RST_PORT;
         edge_q <= `VIRU_RST_REQ;
         gie_q <= 1'b0;
         mask_q <= `VIRU_RST_STAT;
      end else if (ce && wr_now) begin
         if (hit(addr_q, `VIRU_OFF_ENA)) ena_q <= hwdata[7:0];
         if (hit(addr_q, `VIRU_OFF_PENA)) pena_q <= hwdata[9:0];
         if (hit(addr_q, `VIRU_OFF_EDGE)) edge_q <= hwdata[7:0];
         if (hit(addr_q, `VIRU_OFF_CTRL)) gie_q <= hwdata[`VIRU_CTRL_GIE];
         if (hit(addr_q, `VIRU_OFF_MASK)) mask_q <= hwdata[2:0];
      end
   end

   // Watchdog cause bit: set by the watchdog, cleared by a read; set wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_cause_q <= 1'b0;
      end else if (ce) begin
         if (watchdog_request) begin
            wdt_cause_q <= 1'b1;
         end else if (rd_now && hit(addr_q, `VIRU_OFF_RCAUSE)) begin
            wdt_cause_q <= 1'b0;
         end
      end
   end

   // Sources held outside the control registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_fetch_q <= 1'b1;
         wdt_pend_q <= 1'b0;
         posc_q <= 1'b0;
         wosc_q <= 1'b0;
         ill_q <= 1'b0;
      end else if (ce) begin
         reset_fetch_q <= reset_fetch_q & ~take_src[`VIRU_SRC_RESET];
         wdt_pend_q <= (wdt_pend_q & ~take_src[`VIRU_SRC_WDT]) | watchdog_request;
         posc_q <= (posc_q & ~take_src[`VIRU_SRC_POSC]) | primary_osc_fail;
         wosc_q <= (wosc_q & ~take_src[`VIRU_SRC_WOSC]) | watchdog_osc_fail;
         ill_q <= (ill_q & ~take_src[`VIRU_SRC_ILL]) | illegal_instruction;
      end
   end

   // Vector offer to the core: latch the winner, hold until acknowledged.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= VIRU_IDLE;
         grant_q <= '0;
         vec_valid_q <= 1'b0;
         vec_addr_q <= 16'h0000;
         vec_trap_q <= 1'b0;
      end else if (ce) begin
         unique case (state_q)
            VIRU_IDLE: begin
               if (found) begin
                  state_q <= VIRU_OFFER;
                  grant_q <= pick;
                  vec_valid_q <= 1'b1;
                  vec_addr_q <= vec_of(pick);
                  vec_trap_q <= is_trap(pick);
               end
            end
            VIRU_OFFER: begin
               if (vec_ack) begin
                  state_q <= VIRU_IDLE;
                  vec_valid_q <= 1'b0;
               end
            end
            default: begin
               state_q <= VIRU_IDLE;
               vec_valid_q <= 1'b0;
            end
         endcase
      end
   end

   // Sticky event status, write one to clear, set wins.
   always_comb begin
      stat_ev = 3'h0;
      stat_ev[`VIRU_STAT_VEC] = take & ~vec_trap_q;
      stat_ev[`VIRU_STAT_TRAP] = take & vec_trap_q;
      stat_ev[`VIRU_STAT_WDT] = watchdog_request;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= `VIRU_RST_STAT;
         irq_q <= 1'b0;
      end else if (ce) begin
         if (wr_now && hit(addr_q, `VIRU_OFF_STAT)) begin
            stat_q <= (stat_q & ~hwdata[2:0]) | stat_ev;
         end else begin
            stat_q <= stat_q | stat_ev;
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign vec_valid = vec_valid_q;
   assign vec_addr = vec_addr_q;
   assign vec_trap = vec_trap_q;
   assign irq = irq_q;

endmodule // viru_top

// [tb/viru_core_model.sv]
// Behavioural processor core that takes offered vectors after a set delay.
// Assumes the vector link of viru_top and a single clock.
`timescale 1ns/1ps
module viru_core_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Vector link
   input wire logic vec_valid,
   input wire logic [15:0] vec_addr,
   output logic vec_ack,
   // Pacing and log
   input wire logic [7:0] delay,
   output logic taken,
   output logic [15:0] taken_addr
);
   logic [7:0] wait_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vec_ack <= 1'b0;
         taken <= 1'b0;
         taken_addr <= 16'h0000;
         wait_q <= 8'h00;
      end else begin
         taken <= 1'b0;
         if (vec_valid && vec_ack) begin
            taken <= 1'b1;
            taken_addr <= vec_addr;
            vec_ack <= 1'b0;
            wait_q <= 8'h00;
         end else if (vec_valid && wait_q >= delay) begin
            vec_ack <= 1'b1;
         end else if (vec_valid) begin
            wait_q <= wait_q + 8'h01;
         end
      end
   end
endmodule // viru_core_model

// [tb/viru_top_monitor.sv]
// Checker of the bus and vector link ports of the request unit.
// Assumes it is bound to viru_top, one clock domain.
`timescale 1ns/1ps
module viru_top_monitor (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Vector link
   input wire logic vec_ack,
   input wire logic vec_valid,
   input wire logic [15:0] vec_addr,
   input wire logic vec_trap
);
   logic rd_take;
   logic wr_take;
   assign rd_take = ce && hsel && hready && htrans[1] && !hwrite;
   assign wr_take = ce && hsel && hready && htrans[1] && hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   rd_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
      else $error("wait state without read");
   vec_hold_a: assert property (ce && vec_valid && !vec_ack |=>
      vec_valid && $stable(vec_addr) && $stable(vec_trap)) else $error("offer not held");
   vec_drop_a: assert property (ce && vec_valid && vec_ack |=> !vec_valid)
      else $error("offer kept after ack");
   trap_kind_a: assert property (vec_valid |->
      vec_trap == (vec_addr inside {16'h0002, 16'h003A, 16'h003C, 16'h0006}))
      else $error("trap flag wrong");
   vec_table_a: assert property (vec_valid |-> !vec_addr[0] && vec_addr inside
      {[16'h0002:16'h0006], [16'h000A:16'h0010], [16'h0016:16'h0026], 16'h0030, 16'h0032,
      16'h003A, 16'h003C}) else $error("vector outside table");
endmodule // viru_top_monitor

bind viru_top viru_top_monitor viru_top_monitor_inst (.hclk, .hresetn, .ce, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .vec_ack, .vec_valid, .vec_addr, .vec_trap);

// [tb/tb.sv]
// Self-checking bench of viru_top with a behavioural core and a vector log.
// Assumes viru_top, viru_core_model and the bound checker are compiled.
`timescale 1ns/1ps
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [11:0] pul = 12'h000;
   logic [7:0] pa = 8'h00;
   logic [1:0] pc = 2'h0;
   logic [7:0] delay = 8'h00;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, vec_ack, vec_valid, vec_trap, irq, taken;
   logic [15:0] vec_addr, taken_addr;
   logic [15:0] exp_q[$];
   int n_fail = 0;
   int checks = 0;

   always #5 hclk = ~hclk;

   viru_top viru_top_inst (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .timer1_request(pul[6]), .timer0_request(pul[5]), .serial_rx_request(pul[4]),
      .serial_tx_request(pul[3]), .converter_request(pul[0]),
      .low_voltage_detector(pul[1]), .comparator_request(pul[2]), .port_a_pins(pa),
      .port_c_pins(pc), .watchdog_request(pul[7]), .primary_osc_fail(pul[8]),
      .watchdog_osc_fail(pul[9]), .illegal_instruction(pul[10]), .vec_ack, .vec_valid,
      .vec_addr, .vec_trap, .irq);
   viru_core_model viru_core_model_inst (.hclk, .hresetn, .vec_valid, .vec_addr, .vec_ack,
      .delay, .taken, .taken_addr);

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0);
      check(rd, want);
   endtask

   task automatic pulse(input logic [11:0] m);
      @(posedge hclk);
      pul <= m;
      @(posedge hclk);
      pul <= 12'h000;
   endtask

   task automatic settle();
      while (exp_q.size() != 0) @(posedge hclk);
      repeat (10) @(posedge hclk);
   endtask

   task automatic pins(input logic [7:0] v, input logic hit);
      for (int i = 7; i >= 0; i--)
         if (hit && v[i] != pa[i]) exp_q.push_back(16'h0018 + 16'(2 * (7 - i)));
      @(posedge hclk);
      pa <= v;
      settle();
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Every vector taken by the core is compared with the next expected one.
   always @(posedge hclk) begin
      if (taken === 1'b1) check(taken_addr, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
   end

   initial begin
      #300000;
      n_fail++;
      stop_test();
   end

   initial begin
      logic [7:0] r;
      void'($urandom(19978));
      exp_q.push_back(16'h0002);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(12'hFC0, 32'h0);
      bus(1'b1, 12'hF00, 32'hFF);
      rdchk(12'hF00, 32'h0);
      settle();
      r = 8'($urandom) & 8'h79;
      bus(1'b1, 12'hFC0, {24'h0, r});
      rdchk(12'hFC0, {24'h0, r});
      bus(1'b1, 12'hFC0, 32'h0);
      $display("test registers done");
      bus(1'b1, 12'hFC4, 32'h79);
      pulse(12'h079);
      rdchk(12'hFC0, 32'h79);
      check(vec_valid, 1'b0);
      bus(1'b1, 12'hFC0, 32'h0);
      rdchk(12'hFC0, 32'h0);
      $display("test polling done");
      bus(1'b1, 12'hFC0, 32'h79);
      exp_q = '{16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0016};
      delay <= 8'h05;
      bus(1'b1, 12'hFD4, 32'h1);
      settle();
      rdchk(12'hFC0, 32'h0);
      delay <= 8'h00;
      $display("test priority done");
      bus(1'b1, 12'hFCC, 32'h3FF);
      bus(1'b1, 12'hFD0, 32'hFF);
      r = 8'($urandom % 255) + 8'h01;
      pins(r, 1'b1);
      pins(8'h00, 1'b0);
      bus(1'b1, 12'hFD0, 32'h0);
      pins(r, 1'b0);
      pins(8'h00, 1'b1);
      exp_q = '{16'h0018, 16'h001A};
      pulse(12'h006);
      settle();
      for (int k = 0; k < 2; k++) begin
         exp_q = '{16'h0030, 16'h0032};
         @(posedge hclk);
         pc <= ~pc;
         settle();
      end
      $display("test pins done");
      bus(1'b1, 12'hFD4, 32'h0);
      bus(1'b1, 12'hFC4, 32'h0);
      bus(1'b1, 12'hFCC, 32'h0);
      exp_q = '{16'h003A, 16'h003C, 16'h0006};
      pulse(12'h700);
      settle();
      bus(1'b1, 12'hFD4, 32'h1);
      exp_q = '{16'h0004};
      pulse(12'h0C0);
      settle();
      rdchk(12'hFC0, 32'h40);
      bus(1'b1, 12'hFC0, 32'h0);
      rdchk(12'hFD8, 32'h20);
      do bus(1'b0, 12'hFD8, 32'h0); while (rd[5] !== 1'b0);
      check(rd, 32'h0);
      $display("test traps done");
      bus(1'b1, 12'hFDC, 32'h7);
      bus(1'b1, 12'hFE0, 32'h4);
      check(irq, 1'b0);
      exp_q = '{16'h0004};
      pulse(12'h080);
      settle();
      check(irq, 1'b1);
      rdchk(12'hFDC, 32'h5);
      bus(1'b1, 12'hFE0, 32'h0);
      repeat (2) @(posedge hclk);
      check(irq, 1'b0);
      bus(1'b1, 12'hFDC, 32'h4);
      rdchk(12'hFDC, 32'h1);
      $display("test interrupt done");
      stop_test();
   end
endmodule // tb
